// file: aspe_pkg.sv
/*
 * Shared constants for the alarm setup panel editor: register map,
 * field positions, reset values, settings pages, edit ranges and timing.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package aspe_pkg;

  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int FLASH_CNT_W = 27;

  // Register byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN_MASK = 8'h04;
  localparam logic [7:0] OFF_PAIR_AND = 8'h08;
  localparam logic [7:0] OFF_MAP_A = 8'h0c;
  localparam logic [7:0] OFF_MAP_B = 8'h10;
  localparam logic [7:0] OFF_MAP_C = 8'h14;
  localparam logic [7:0] OFF_MAP_D = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_EDIT = 8'h20;
  localparam logic [7:0] OFF_ALARMS = 8'h24;

  // Control register fields
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_FLASH_BIT = 1;

  // Reset values
  localparam logic RST_GLOBAL = 1'b0;
  localparam logic RST_FLASH = 1'b0;
  localparam logic [15:0] RST_MASK16 = 16'h0000;
  localparam logic [7:0] RST_AND8 = 8'h00;

  // Widths
  localparam int NUM_CHAN = 16;
  localparam int NUM_PAIR = 8;
  localparam int NUM_OUT = 4;
  localparam int EV_W = 17;
  localparam int PAGE_ID_W = 8;

  // Settings pages, browsed in this order
  localparam logic [2:0] PG_GLOBAL = 3'h0;
  localparam logic [2:0] PG_FLASH = 3'h1;
  localparam logic [2:0] PG_CHAN = 3'h2;
  localparam logic [2:0] PG_AND = 3'h3;
  localparam logic [2:0] PG_MAP_A = 3'h4;
  localparam logic [2:0] PAGE_FIRST = 3'h0;
  localparam logic [2:0] PAGE_LAST = 3'h7;

  // Edit ranges and digit counts
  localparam logic [EV_W-1:0] MAX_MASK = 17'h0ffff;
  localparam logic [EV_W-1:0] MAX_AND = 17'h000ff;
  localparam logic [EV_W-1:0] MAX_YESNO = 17'h00001;
  localparam logic [2:0] DIG_MASK = 3'h5;
  localparam logic [2:0] DIG_AND = 3'h3;
  localparam logic [2:0] DIG_YESNO = 3'h1;

  // Display page identifiers for recovery
  localparam logic [PAGE_ID_W-1:0] PAGE_ID_VOLT = 8'h01;
  localparam logic [PAGE_ID_W-1:0] EXP_VIEW_FIRST = 8'h30;
  localparam logic [PAGE_ID_W-1:0] EXP_VIEW_LAST = 8'h3f;
  localparam int EXP_MOD_BIT = 0;
  localparam int NV_PARAM_BIT = 8;

  typedef enum logic [1:0] {
    MODE_DISPLAY,
    MODE_SELECT,
    MODE_BROWSE,
    MODE_EDIT
  } aspe_mode_e;

endpackage

// file: aspe_editor.sv
/*
 * Alarm setup panel editor: keypad-driven browse/edit of global alarm
 * settings, AND-pair combining, output routing, backlight flash and
 * display page recovery, with an Avalon-MM register slave.
 * Assumes key pulses, channel triggers and module presence come from
 * logic on sys_clk; only power_good arrives from outside and is synchronised.
 */
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module aspe_editor
  import aspe_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYCLES = FLASH_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic param_enter,
  input wire logic key_back,
  input wire logic key_next,
  input wire logic key_prev,
  input wire logic key_select,
  output logic [1:0] ui_mode,
  output logic [2:0] ui_page,
  output logic [EV_W-1:0] ui_edit_value,
  output logic [2:0] ui_edit_cursor,
  input wire logic [NUM_CHAN-1:0] chan_trig,
  input wire logic [NUM_OUT-1:0] out_alarm_mode,
  input wire logic [1:0] module_present,
  output logic alarm_output_line_a,
  output logic alarm_output_line_b,
  output logic alarm_output_line_c,
  output logic alarm_output_line_d,
  output logic backlight_flash,
  input wire logic power_good,
  input wire logic [PAGE_ID_W-1:0] cur_page_id,
  output logic nv_save_strobe,
  output logic [PAGE_ID_W:0] nv_save_data,
  output logic nv_load_req,
  input wire logic nv_load_valid,
  input wire logic [PAGE_ID_W:0] nv_load_data,
  output logic restore_valid,
  output logic [PAGE_ID_W-1:0] restore_page
);

  function automatic logic [EV_W-1:0] digit_weight(input logic [2:0] pos);
    logic [EV_W-1:0] w;
    w = 17'h00001;
    unique case (pos)
      3'h1: w = 17'h0000a;
      3'h2: w = 17'h00064;
      3'h3: w = 17'h003e8;
      3'h4: w = 17'h02710;
      default: w = 17'h00001;
    endcase
    return w;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // Settings and bus state
  logic glob_reg, glob_next, flash_en_reg, flash_en_next;
  logic [15:0] chan_mask_reg, chan_mask_next;
  logic [7:0] pair_and_reg, pair_and_next;
  logic [15:0] map_reg [NUM_OUT];
  logic [15:0] map_next [NUM_OUT];
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;

  // Panel state
  aspe_mode_e mode_reg, mode_next;
  logic [2:0] page_reg, page_next, cur_reg, cur_next;
  logic [EV_W-1:0] edit_reg, edit_next;
  logic commit;
  logic [EV_W-1:0] page_val, page_max, w;
  logic [2:0] page_dig;
  logic [1:0] map_idx;

  // Alarm, flash and recovery state
  logic [NUM_CHAN-1:0] gated, eff;
  logic alarm_any;
  logic [NUM_OUT-1:0] out_reg, out_next;
  logic [FLASH_CNT_W-1:0] fcnt_reg, fcnt_next;
  logic bl_reg, bl_next;
  logic pg_s1_reg, pg_s2_reg, pg_prev_reg;
  logic save_reg, save_next, load_reg, load_next, rvalid_reg, rvalid_next;
  logic [PAGE_ID_W:0] sdata_reg, sdata_next;
  logic [PAGE_ID_W-1:0] rpage_reg, rpage_next, ld_id;
  logic bus_req, bus_fire;

  assign bus_req = avs_read | avs_write;
  assign bus_fire = avs_write & ~wait_reg;
  assign map_idx = 2'(page_reg - PG_MAP_A);

  // Value, range and digit count of the current page
  always_comb begin
    page_val = '0;
    page_max = MAX_MASK;
    page_dig = DIG_MASK;
    unique case (page_reg)
      PG_GLOBAL: begin
        page_val = {16'h0000, glob_reg};
        page_max = MAX_YESNO;
        page_dig = DIG_YESNO;
      end
      PG_FLASH: begin
        page_val = {16'h0000, flash_en_reg};
        page_max = MAX_YESNO;
        page_dig = DIG_YESNO;
      end
      PG_CHAN: page_val = {1'b0, chan_mask_reg};
      PG_AND: begin
        page_val = {9'h000, pair_and_reg};
        page_max = MAX_AND;
        page_dig = DIG_AND;
      end
      default: page_val = {1'b0, map_reg[map_idx]};
    endcase
  end

  // Panel state machine; single-key pulses make the if-chain exclusive
  always_comb begin
    mode_next = mode_reg;
    page_next = page_reg;
    cur_next = cur_reg;
    edit_next = edit_reg;
    commit = 1'b0;
    w = digit_weight(cur_reg);
    unique case (mode_reg)
      MODE_DISPLAY: begin
        if (param_enter) mode_next = MODE_SELECT;
      end
      MODE_SELECT: begin
        if (key_select) begin
          mode_next = MODE_BROWSE;
          page_next = PAGE_FIRST;
        end else if (key_back) begin
          mode_next = MODE_DISPLAY;
        end
      end
      MODE_BROWSE: begin
        if (key_back) begin
          mode_next = MODE_SELECT;
        end else if (key_next) begin
          page_next = (page_reg == PAGE_LAST) ? PAGE_FIRST : page_reg + 3'h1;
        end else if (key_prev) begin
          page_next = (page_reg == PAGE_FIRST) ? PAGE_LAST : page_reg - 3'h1;
        end else if (key_select) begin
          mode_next = MODE_EDIT;
          edit_next = page_val;
          cur_next = page_dig - 3'h1;
        end
      end
      MODE_EDIT: begin
        if (key_back) begin
          cur_next = (cur_reg == 3'h0) ? page_dig - 3'h1 : cur_reg - 3'h1;
        end else if (key_next) begin
          if (edit_reg + w <= page_max) edit_next = edit_reg + w;
        end else if (key_prev) begin
          if (edit_reg >= w) edit_next = edit_reg - w;
        end else if (key_select) begin
          commit = 1'b1;
          mode_next = MODE_BROWSE;
        end
      end
    endcase
    // A fresh power-up restarts the panel on the display side
    if (nv_load_valid) mode_next = MODE_DISPLAY;
  end

  // Settings: panel commit, then bus write, so software wins a tie
  always_comb begin
    glob_next = glob_reg;
    flash_en_next = flash_en_reg;
    chan_mask_next = chan_mask_reg;
    pair_and_next = pair_and_reg;
    map_next = map_reg;
    if (commit) begin
      unique case (page_reg)
        PG_GLOBAL: glob_next = edit_reg[0];
        PG_FLASH: flash_en_next = edit_reg[0];
        PG_CHAN: chan_mask_next = edit_reg[15:0];
        PG_AND: pair_and_next = edit_reg[7:0];
        default: map_next[map_idx] = edit_reg[15:0];
      endcase
    end
    if (bus_fire) begin
      unique case (avs_address)
        OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            glob_next = avs_writedata[CTRL_GLOBAL_BIT];
            flash_en_next = avs_writedata[CTRL_FLASH_BIT];
          end
        end
        OFF_CHAN_MASK: chan_mask_next = merge16(chan_mask_reg, avs_writedata, avs_byteenable);
        OFF_PAIR_AND: begin
          if (avs_byteenable[0]) pair_and_next = avs_writedata[7:0];
        end
        OFF_MAP_A: map_next[0] = merge16(map_reg[0], avs_writedata, avs_byteenable);
        OFF_MAP_B: map_next[1] = merge16(map_reg[1], avs_writedata, avs_byteenable);
        OFF_MAP_C: map_next[2] = merge16(map_reg[2], avs_writedata, avs_byteenable);
        OFF_MAP_D: map_next[3] = merge16(map_reg[3], avs_writedata, avs_byteenable);
        default: glob_next = glob_reg;
      endcase
    end
  end

  // Bus answer: one wait cycle, then readdata with waitrequest low
  always_comb begin
    wait_next = !(bus_req && wait_reg);
    rdata_next = rdata_reg;
    if (avs_read && wait_reg) begin
      unique case (avs_address)
        OFF_CTRL: rdata_next = {30'h0, flash_en_reg, glob_reg};
        OFF_CHAN_MASK: rdata_next = {16'h0000, chan_mask_reg};
        OFF_PAIR_AND: rdata_next = {24'h000000, pair_and_reg};
        OFF_MAP_A: rdata_next = {16'h0000, map_reg[0]};
        OFF_MAP_B: rdata_next = {16'h0000, map_reg[1]};
        OFF_MAP_C: rdata_next = {16'h0000, map_reg[2]};
        OFF_MAP_D: rdata_next = {16'h0000, map_reg[3]};
        OFF_STATUS: rdata_next = {20'h00000, out_reg, alarm_any, bl_reg, mode_reg, 1'b0, page_reg};
        OFF_EDIT: rdata_next = {12'h000, cur_reg, edit_reg};
        OFF_ALARMS: rdata_next = {16'h0000, eff};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Pair combining: pair p covers channels 2p and 2p+1
  generate
    for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
      assign gated[2*p] = glob_reg & chan_mask_reg[2*p] & chan_trig[2*p];
      assign gated[2*p+1] = glob_reg & chan_mask_reg[2*p+1] & chan_trig[2*p+1];
      assign eff[2*p] = pair_and_reg[p] ? (gated[2*p] & gated[2*p+1]) : gated[2*p];
      assign eff[2*p+1] = pair_and_reg[p] ? (gated[2*p] & gated[2*p+1]) : gated[2*p+1];
    end
    // Lines a,b ride on the first module, c,d on the second
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
      assign out_next[o] = out_alarm_mode[o] & module_present[o/2] & (|(eff & map_reg[o]));
    end
  endgenerate

  assign alarm_any = |eff;

  // Flash only while an alarm stands; a cleared alarm leaves backlight steady
  always_comb begin
    fcnt_next = '0;
    bl_next = 1'b0;
    if (flash_en_reg && alarm_any) begin
      bl_next = bl_reg;
      fcnt_next = fcnt_reg + 1'b1;
      if (fcnt_reg == FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) begin
        fcnt_next = '0;
        bl_next = ~bl_reg;
      end
    end
  end

  // Page recovery
  always_comb begin
    save_next = 1'b0;
    load_next = 1'b0;
    rvalid_next = 1'b0;
    sdata_next = sdata_reg;
    rpage_next = rpage_reg;
    ld_id = nv_load_data[PAGE_ID_W-1:0];
    if (pg_prev_reg && !pg_s2_reg) begin
      save_next = 1'b1;
      sdata_next = {mode_reg != MODE_DISPLAY, cur_page_id};
    end
    if (!pg_prev_reg && pg_s2_reg) load_next = 1'b1;
    if (nv_load_valid) begin
      rvalid_next = 1'b1;
      rpage_next = ld_id;
      if (nv_load_data[NV_PARAM_BIT]) begin
        rpage_next = PAGE_ID_VOLT;
      end else if (ld_id >= EXP_VIEW_FIRST && ld_id <= EXP_VIEW_LAST && !module_present[ld_id[EXP_MOD_BIT]]) begin
        rpage_next = PAGE_ID_VOLT;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      glob_reg <= RST_GLOBAL;
      flash_en_reg <= RST_FLASH;
      chan_mask_reg <= RST_MASK16;
      pair_and_reg <= RST_AND8;
      for (int i = 0; i < NUM_OUT; i++) map_reg[i] <= RST_MASK16;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      mode_reg <= MODE_DISPLAY;
      page_reg <= PAGE_FIRST;
      cur_reg <= '0;
      edit_reg <= '0;
      out_reg <= '0;
      fcnt_reg <= '0;
      bl_reg <= 1'b0;
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
      save_reg <= 1'b0;
      load_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      sdata_reg <= '0;
      rpage_reg <= PAGE_ID_VOLT;
    end else begin
      glob_reg <= glob_next;
      flash_en_reg <= flash_en_next;
      chan_mask_reg <= chan_mask_next;
      pair_and_reg <= pair_and_next;
      map_reg <= map_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      page_reg <= page_next;
      cur_reg <= cur_next;
      edit_reg <= edit_next;
      out_reg <= out_next;
      fcnt_reg <= fcnt_next;
      bl_reg <= bl_next;
      pg_s1_reg <= power_good;
      pg_s2_reg <= pg_s1_reg;
      pg_prev_reg <= pg_s2_reg;
      save_reg <= save_next;
      load_reg <= load_next;
      rvalid_reg <= rvalid_next;
      sdata_reg <= sdata_next;
      rpage_reg <= rpage_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign ui_mode = mode_reg;
  assign ui_page = page_reg;
  assign ui_edit_value = edit_reg;
  assign ui_edit_cursor = cur_reg;
  assign alarm_output_line_a = out_reg[0];
  assign alarm_output_line_b = out_reg[1];
  assign alarm_output_line_c = out_reg[2];
  assign alarm_output_line_d = out_reg[3];
  assign backlight_flash = bl_reg;
  assign nv_save_strobe = save_reg;
  assign nv_save_data = sdata_reg;
  assign nv_load_req = load_reg;
  assign restore_valid = rvalid_reg;
  assign restore_page = rpage_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_chan_commit;
    mode_reg == MODE_EDIT && key_select && page_reg == PG_CHAN && !bus_fire;
  endsequence
  sequence s_back_browse;
    mode_reg == MODE_BROWSE && chan_mask_reg == $past(edit_reg[15:0]);
  endsequence

  browse_back_a: assert property (mode_reg == MODE_BROWSE && key_back |=> mode_reg == MODE_SELECT)
    else $error("back key did not leave browsing");
  next_wrap_a: assert property (mode_reg == MODE_BROWSE && key_next && page_reg == PAGE_LAST
    |=> page_reg == PAGE_FIRST)
    else $error("next key did not wrap to first page");
  prev_wrap_a: assert property (mode_reg == MODE_BROWSE && key_prev && page_reg == PAGE_FIRST
    |=> page_reg == PAGE_LAST)
    else $error("previous key did not wrap to last page");
  enter_edit_a: assert property (mode_reg == MODE_BROWSE && key_select && !key_back
    |=> mode_reg == MODE_EDIT && edit_reg == $past(page_val))
    else $error("select did not load the page value for edit");
  cursor_step_a: assert property (mode_reg == MODE_EDIT && key_back && cur_reg != 3'h0
    |=> cur_reg == $past(cur_reg) - 3'h1)
    else $error("cursor did not move one digit");
  edit_inc_a: assert property (mode_reg == MODE_EDIT && key_next && cur_reg == 3'h0 && edit_reg < page_max
    |=> edit_reg == $past(edit_reg) + 17'h00001)
    else $error("next key did not add one");
  mask_commit_a: assert property (s_chan_commit |=> s_back_browse)
    else $error("channel mask commit failed");
  global_off_a: assert property (!glob_reg |=> out_reg == '0 ##1 (glob_reg || !bl_reg))
    else $error("outputs active with global enable off");
  flash_off_a: assert property (!flash_en_reg |=> !bl_reg)
    else $error("backlight flashed with flash disabled");
  and_pair_a: assert property (pair_and_reg[0] && !chan_trig[1] |-> !eff[0] && !eff[1])
    else $error("AND pair alarmed with one channel quiet");
  save_page_a: assert property (pg_prev_reg && !pg_s2_reg
    |=> nv_save_strobe && nv_save_data[PAGE_ID_W-1:0] == $past(cur_page_id))
    else $error("page not saved on power loss");
  param_volt_a: assert property (nv_load_valid && nv_load_data[NV_PARAM_BIT]
    |=> restore_valid && restore_page == PAGE_ID_VOLT)
    else $error("parameter-mode loss did not restore voltage page");

endmodule

`default_nettype wire

// file: aspe_panel_model.sv
/*
 * Front-panel partner: keypad pulses and the non-volatile page store.
 * Assumes the editor samples keys and strobes on the rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module aspe_panel_model
  import aspe_pkg::*;
(
  input wire logic sys_clk,
  output var logic param_enter,
  output var logic key_back,
  output var logic key_next,
  output var logic key_prev,
  output var logic key_select,
  input wire logic nv_save_strobe,
  input wire logic [PAGE_ID_W:0] nv_save_data,
  input wire logic nv_load_req,
  output var logic nv_load_valid,
  output var logic [PAGE_ID_W:0] nv_load_data
);
  logic [PAGE_ID_W:0] nv_word = {1'b0, PAGE_ID_VOLT};

  initial begin
    {param_enter, key_back, key_next, key_prev, key_select} = 5'h00;
    nv_load_valid = 1'b0;
    nv_load_data = 9'h000;
  end

  // One debounced key for one cycle, never two at once
  task automatic press(input int k);
    @(posedge sys_clk);
    {key_select, key_prev, key_next, key_back, param_enter} <= 5'h01 << k;
    @(posedge sys_clk);
    {key_select, key_prev, key_next, key_back, param_enter} <= 5'h00;
  endtask

  // Idle data shows the inverse so a stale word cannot pass
  always @(posedge sys_clk) begin
    nv_load_valid <= 1'b0;
    nv_load_data <= ~nv_word;
    if (nv_save_strobe === 1'b1) begin
      nv_word <= nv_save_data;
    end
    if (nv_load_req === 1'b1) begin
      nv_load_valid <= 1'b1;
      nv_load_data <= nv_word;
    end
  end
endmodule

`default_nettype wire

// file: testbench.sv
/*
 * Self-checking bench for the alarm setup panel editor.
 * Assumes the panel model in its own file and a shortened flash period.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
  import aspe_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic param_enter, key_back, key_next, key_prev, key_select;
  logic [1:0] ui_mode;
  logic [2:0] ui_page, ui_edit_cursor;
  logic [EV_W-1:0] ui_edit_value;
  logic [NUM_CHAN-1:0] chan_trig = 16'h0000;
  logic [NUM_OUT-1:0] out_alarm_mode = 4'h0;
  logic [1:0] module_present = 2'h0;
  logic line_a, line_b, line_c, line_d, backlight_flash;
  logic power_good = 1'b1;
  logic [7:0] cur_page_id = 8'h00;
  logic nv_save_strobe, nv_load_req, nv_load_valid, restore_valid;
  logic [8:0] nv_save_data, nv_load_data;
  logic [7:0] restore_page;
  int fail_count = 0;
  int checks = 0;

  always #2 sys_clk = ~sys_clk;

  aspe_editor #(.FLASH_HALF_CYCLES(4)) uut (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .param_enter(param_enter), .key_back(key_back),
    .key_next(key_next), .key_prev(key_prev), .key_select(key_select), .ui_mode(ui_mode),
    .ui_page(ui_page), .ui_edit_value(ui_edit_value), .ui_edit_cursor(ui_edit_cursor),
    .chan_trig(chan_trig), .out_alarm_mode(out_alarm_mode), .module_present(module_present),
    .alarm_output_line_a(line_a), .alarm_output_line_b(line_b), .alarm_output_line_c(line_c),
    .alarm_output_line_d(line_d), .backlight_flash(backlight_flash), .power_good(power_good),
    .cur_page_id(cur_page_id), .nv_save_strobe(nv_save_strobe), .nv_save_data(nv_save_data),
    .nv_load_req(nv_load_req), .nv_load_valid(nv_load_valid), .nv_load_data(nv_load_data),
    .restore_valid(restore_valid), .restore_page(restore_page));

  aspe_panel_model panel (.sys_clk(sys_clk), .param_enter(param_enter), .key_back(key_back),
    .key_next(key_next), .key_prev(key_prev), .key_select(key_select),
    .nv_save_strobe(nv_save_strobe), .nv_save_data(nv_save_data), .nv_load_req(nv_load_req),
    .nv_load_valid(nv_load_valid), .nv_load_data(nv_load_data));

  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // No local limit: a hung slave is left to the watchdog
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic key(input int k, input logic [1:0] m, input logic [2:0] p);
    panel.press(k);
    @(posedge sys_clk);
    chk({27'h0, ui_mode, ui_page}, {27'h0, m, p});
  endtask

  task automatic edchk(input logic [2:0] cur, input logic [EV_W-1:0] v);
    chk({12'h0, ui_edit_cursor, ui_edit_value}, {12'h0, cur, v});
  endtask

  task automatic outs(input logic [3:0] exp);
    repeat (3) @(posedge sys_clk);
    chk({28'h0, line_d, line_c, line_b, line_a}, {28'h0, exp});
  endtask

  task automatic power_cycle(input logic [7:0] exp);
    power_good <= 1'b0;
    repeat (12) @(posedge sys_clk);
    power_good <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (restore_valid !== 1'b1);
    chk({24'h0, restore_page}, {24'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    int tog;
    logic last;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_CHAN_MASK, 32'h0);
    wr(OFF_PAIR_AND, 32'h1ff);
    rdchk(OFF_PAIR_AND, 32'hff);
    rdchk(8'h40, 32'h0);
    wr(OFF_CHAN_MASK, 32'h1);
    key(0, 2'd1, 3'd0);
    key(4, 2'd2, PAGE_FIRST);
    key(3, 2'd2, PAGE_LAST);
    key(2, 2'd2, PAGE_FIRST);
    key(2, 2'd2, PG_FLASH);
    key(2, 2'd2, PG_CHAN);
    key(4, 2'd3, PG_CHAN);
    edchk(3'd4, 17'd1);
    key(2, 2'd3, PG_CHAN);
    edchk(3'd4, 17'd10001);
    key(1, 2'd3, PG_CHAN);
    edchk(3'd3, 17'd10001);
    key(3, 2'd3, PG_CHAN);
    edchk(3'd3, 17'd9001);
    key(4, 2'd2, PG_CHAN);
    rdchk(OFF_CHAN_MASK, 32'd9001);
    key(3, 2'd2, PG_FLASH);
    key(3, 2'd2, PG_GLOBAL);
    key(4, 2'd3, PG_GLOBAL);
    key(2, 2'd3, PG_GLOBAL);
    key(4, 2'd2, PG_GLOBAL);
    rdchk(OFF_CTRL, 32'h1);
    key(2, 2'd2, PG_FLASH);
    key(2, 2'd2, PG_CHAN);
    key(2, 2'd2, PG_AND);
    key(4, 2'd3, PG_AND);
    edchk(3'd2, 17'd255);
    key(2, 2'd3, PG_AND);
    edchk(3'd2, 17'd255);
    key(3, 2'd3, PG_AND);
    edchk(3'd2, 17'd155);
    rdchk(OFF_EDIT, 32'h0004009b);
    key(4, 2'd2, PG_AND);
    rdchk(OFF_PAIR_AND, 32'd155);
    key(2, 2'd2, PG_MAP_A);
    key(4, 2'd3, PG_MAP_A);
    key(2, 2'd3, PG_MAP_A);
    edchk(3'd4, 17'd10000);
    key(4, 2'd2, PG_MAP_A);
    rdchk(OFF_MAP_A, 32'd10000);
    key(1, 2'd1, PG_MAP_A);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_CHAN_MASK, 32'hffff);
    wr(OFF_PAIR_AND, 32'h01);
    wr(OFF_MAP_A, 32'h0001);
    wr(OFF_MAP_B, 32'h0002);
    wr(OFF_MAP_C, 32'h0100);
    wr(OFF_MAP_D, 32'h0200);
    out_alarm_mode <= 4'hf;
    module_present <= 2'b11;
    chan_trig <= 16'h0001;
    outs(4'b0000);
    chan_trig <= 16'h0103;
    outs(4'b0111);
    wr(OFF_CHAN_MASK, 32'hfeff);
    outs(4'b0011);
    wr(OFF_CHAN_MASK, 32'hffff);
    wr(OFF_PAIR_AND, 32'h11);
    outs(4'b0011);
    rdchk(OFF_ALARMS, 32'h3);
    chan_trig <= 16'h0303;
    outs(4'b1111);
    module_present <= 2'b01;
    outs(4'b0011);
    tog = 0;
    last = backlight_flash;
    repeat (24) begin
      @(posedge sys_clk);
      if (backlight_flash !== last) tog++;
      last = backlight_flash;
    end
    chk({31'h0, tog >= 4}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    outs(4'b0000);
    wr(OFF_CTRL, 32'h1);
    chan_trig <= 16'h0000;
    outs(4'b0000);
    cur_page_id <= 8'h05;
    power_cycle(PAGE_ID_VOLT);
    chk({30'h0, ui_mode}, 32'h0);
    power_cycle(8'h05);
    cur_page_id <= 8'h31;
    power_cycle(PAGE_ID_VOLT);
    module_present <= 2'b11;
    power_cycle(8'h31);
    give_verdict();
  end
endmodule

`default_nettype wire
